//--- hw/irfp_top.v
// infrared remote fifo port: wishbone registers, receive and transmit frame fifos
// Functional notes
// RQ1: tx frame done flag sets after a sent frame; cleared by writing 0.
// RQ2: rx fill count gives bytes held; 0x00 empty, 0xFF full.
// RQ3: tx pending count gives unsent data bytes; 0x00 none, 0xFF full.
// RQ4: rx fifo port is 8-bit read-only, returns next byte each read.
// RQ5: tx fifo port is 8-bit write-only, each write appends a byte.
// RQ6: event flag bit 4 sets on frame sent or received; cleared writing 0.
// RQ7: software sets the format bit before setting enable.
// RQ8: enable bit starts operation including reception.
// RQ9: rx interrupt enable raises interrupt when a received frame is stored.
// RQ10: received frame delivered as count byte then data bytes.
// RQ11: rx fill count totals all buffered frames.
// RQ12: software writes count byte first; count byte not in pending count.
// RQ13: software writes only while pending count is below 255.
// RQ14: tx interrupt enable raises interrupt after a frame is sent.
// RQ15: software expects no traffic while enable is 0.
// RQ16: reads past held bytes return FF.
// RQ17: device adds leader, stop, space and trailer around the codes; code sends leader, then stop (format 0) or trailer (format 1), then space.
// RQ18: writes beyond 255 minus pending raise a data length error.
// RQ19: full rx fifo sets overflow error and discards further data.
// RQ20: format bit 0 selects first air format, 1 the second.
// RQ21: rx frame done flag sets after a received frame; cleared by writing 0.
// RQ22: rx fifo holds up to 255 bytes; a multi-byte frame can bring it to 256, wrapping the fill count to 0.
// RQ23: writing 1 to a flag leaves it unchanged.
// RQ24: each rx port read removes the byte and decrements the fill count.
`timescale 1ns/1ps
`include "irfp_regs.vh"

module irfp_top #(
    parameter RX_AW = 8,
    parameter TX_AW = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // receive byte stream from the pulse decoder
    input wire rx_byte_valid_i,
    input wire [7:0] rx_byte_i,
    input wire rx_frame_end_i,
    // transmit symbol stream to the pulse encoder
    output wire tx_sym_valid_o,
    output reg [2:0] tx_sym_o,
    input wire tx_sym_ready_i,
    // mode and interrupt
    output wire ir_enable_o,
    output wire ir_format_o,
    output wire irq_o
);

    // ==========================================================
    // bus decode
    wire req_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0] idx = wb_adr_i[9:2];
    wire hit = (wb_adr_i[11:10] == 2'h0);
    wire wr_lo = req_take & wb_we_i & wb_sel_i[0] & hit;
    wire rd_acc = req_take & ~wb_we_i & hit;
    wire [7:0] wdat = wb_dat_i[7:0];

    reg [3:0] ctrl_reg;
    reg rx_done_reg, tx_done_reg, rx_ovf_reg, event_reg, tx_err_reg;
    reg [RX_AW-1:0] rx_fill_reg, rx_rd_reg, rx_wr_reg, rx_fwr_reg, rx_slot_reg, rx_len_reg;
    reg rx_infr_reg, rx_drop_reg;
    reg [7:0] rx_mem [0:(1<<RX_AW)-1];
    reg [7:0] tx_mem [0:(1<<TX_AW)-1];
    reg [TX_AW-1:0] tx_wr_reg, tx_rd_reg;
    reg [TX_AW:0] tx_used_reg;
    reg [7:0] tx_pend_reg, tx_left_reg, tx_frames_reg, tx_bytes_reg, tx_sh_reg;
    reg [2:0] tx_bit_reg, tx_st_reg;

    // ==========================================================
    // control and flags
    assign ir_enable_o = ctrl_reg[`IRFP_CTRL_START];  // [RQ8]
    assign ir_format_o = ctrl_reg[`IRFP_CTRL_FORMAT];  // [RQ20]
    wire rx_commit;
    wire tx_sent;
    wire rx_over_ev;
    wire st_wr = wr_lo & (idx == `IRFP_IDX_STAT);
    wire ev_wr = wr_lo & (idx == `IRFP_IDX_EVENT);
    wire er_wr = wr_lo & (idx == `IRFP_IDX_TXERR);
    wire tx_err_ev;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `IRFP_RST_CTRL;
            rx_done_reg <= 1'b0;
            tx_done_reg <= 1'b0;
            rx_ovf_reg <= 1'b0;
            event_reg <= 1'b0;
            tx_err_reg <= 1'b0;
        end else begin
            if (wr_lo && idx == `IRFP_IDX_CTRL) begin
                ctrl_reg <= wdat[3:0];
            end
            // set wins over clear; writing 1 keeps the flag
            rx_done_reg <= rx_commit | (rx_done_reg & ~(st_wr & ~wdat[`IRFP_STAT_RXDONE])); // [RQ21] [RQ23]
            tx_done_reg <= tx_sent | (tx_done_reg & ~(st_wr & ~wdat[`IRFP_STAT_TXDONE])); // [RQ1] [RQ23]
            rx_ovf_reg <= rx_over_ev | (rx_ovf_reg & ~(st_wr & ~wdat[`IRFP_STAT_RXOVF])); // [RQ19]
            event_reg <= rx_commit | tx_sent
                | (event_reg & ~(ev_wr & ~wdat[`IRFP_EVENT_IR]));  // [RQ6] [RQ23]
            tx_err_reg <= tx_err_ev | (tx_err_reg & ~(er_wr & ~wdat[`IRFP_TXERR_LEN])); // [RQ18]
        end
    end

    assign irq_o = (rx_done_reg & ctrl_reg[`IRFP_CTRL_RXIE])  // [RQ9]
        | (tx_done_reg & ctrl_reg[`IRFP_CTRL_TXIE]);  // [RQ14]

    // ==========================================================
    // receive fifo
    wire rx_pop = rd_acc & (idx == `IRFP_IDX_RXPORT) & (rx_fill_reg != 0);  // [RQ24]
    wire rx_on = ctrl_reg[`IRFP_CTRL_START];
    wire rx_take = rx_on & rx_byte_valid_i & ~rx_frame_end_i;
    wire [RX_AW:0] rx_need = {1'b0, rx_fill_reg} + {1'b0, rx_len_reg}
        + (rx_infr_reg ? {{RX_AW{1'b0}}, 1'b1} : {{(RX_AW-1){1'b0}}, 2'h2});
    wire rx_room = (rx_need <= {1'b0, {RX_AW{1'b1}}});  // [RQ22]
    wire rx_store = rx_take & ~rx_drop_reg & rx_room;
    assign rx_over_ev = rx_take & ~rx_drop_reg & ~rx_room;  // [RQ19]
    assign rx_commit = rx_frame_end_i & rx_infr_reg & ~rx_drop_reg;
    wire [RX_AW-1:0] rx_add = rx_commit ? rx_len_reg + 1'b1 : {RX_AW{1'b0}};

    always @(posedge clk_i) begin
        if (rx_commit) begin
            rx_mem[rx_slot_reg] <= rx_len_reg;  // [RQ10]
        end else if (rx_store) begin
            rx_mem[rx_infr_reg ? rx_fwr_reg : rx_wr_reg + 1'b1] <= rx_byte_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_fill_reg <= {RX_AW{1'b0}};
            rx_rd_reg <= {RX_AW{1'b0}};
            rx_wr_reg <= {RX_AW{1'b0}};
            rx_fwr_reg <= {RX_AW{1'b0}};
            rx_slot_reg <= {RX_AW{1'b0}};
            rx_len_reg <= {RX_AW{1'b0}};
            rx_infr_reg <= 1'b0;
            rx_drop_reg <= 1'b0;
        end else begin
            rx_fill_reg <= rx_fill_reg + rx_add - {{(RX_AW-1){1'b0}}, rx_pop};  // [RQ2] [RQ11]
            if (rx_pop) begin
                rx_rd_reg <= rx_rd_reg + 1'b1;
            end
            if (rx_frame_end_i) begin
                if (rx_commit) begin
                    rx_wr_reg <= rx_fwr_reg;
                end
                rx_infr_reg <= 1'b0;
                rx_drop_reg <= 1'b0;
                rx_len_reg <= {RX_AW{1'b0}};
            end else if (rx_over_ev) begin
                rx_drop_reg <= 1'b1;  // [RQ19]
            end else if (rx_store) begin
                if (!rx_infr_reg) begin
                    rx_slot_reg <= rx_wr_reg;
                    rx_fwr_reg <= rx_wr_reg + 2'h2;
                end else begin
                    rx_fwr_reg <= rx_fwr_reg + 1'b1;
                end
                rx_infr_reg <= 1'b1;
                rx_len_reg <= rx_len_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // transmit fifo writer
    wire tx_push_req = wr_lo & (idx == `IRFP_IDX_TXPORT);  // [RQ5]
    wire tx_full = (tx_used_reg == (1 << TX_AW));
    wire tx_is_cnt = (tx_left_reg == 8'h00);
    wire [7:0] tx_space = `IRFP_MAX_COUNT - tx_pend_reg;
    wire tx_bad = tx_full | (tx_is_cnt ? (wdat > tx_space) : (tx_pend_reg == `IRFP_MAX_COUNT));
    wire tx_push = tx_push_req & ~tx_bad;
    assign tx_err_ev = tx_push_req & tx_bad;  // [RQ18]
    wire tx_frame_in = tx_push & (tx_is_cnt ? (wdat == 8'h00) : (tx_left_reg == 8'h01));
    wire tx_data_in = tx_push & ~tx_is_cnt;  // [RQ12]

    always @(posedge clk_i) begin
        if (tx_push) begin
            tx_mem[tx_wr_reg] <= wdat;
        end
    end

    // ==========================================================
    // transmit framer
    localparam T_IDLE = 3'h0;
    localparam T_LEAD = 3'h1;
    localparam T_LOAD = 3'h2;
    localparam T_BITS = 3'h3;
    localparam T_END = 3'h4;
    localparam T_SPACE = 3'h5;

    wire [7:0] tx_head = tx_mem[tx_rd_reg];
    wire tx_go = tx_sym_ready_i & tx_sym_valid_o;
    wire tx_start = (tx_st_reg == T_IDLE) & ctrl_reg[`IRFP_CTRL_START] & (tx_frames_reg != 0);
    wire tx_fpop = (tx_st_reg == T_LEAD) & tx_go;
    wire tx_dpop = (tx_st_reg == T_LOAD);
    wire tx_bdone = (tx_st_reg == T_BITS) & tx_go & (tx_bit_reg == 3'h7);
    wire tx_rpop = tx_fpop | tx_dpop;
    assign tx_sent = (tx_st_reg == T_SPACE) & tx_go;
    assign tx_sym_valid_o = (tx_st_reg == T_LEAD) | (tx_st_reg == T_BITS)
        | (tx_st_reg == T_END) | (tx_st_reg == T_SPACE);
    wire [2:0] tx_tail = ctrl_reg[`IRFP_CTRL_FORMAT] ? `IRFP_SYM_TRAILER : `IRFP_SYM_STOP;

    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_wr_reg <= {TX_AW{1'b0}};
            tx_rd_reg <= {TX_AW{1'b0}};
            tx_used_reg <= {(TX_AW+1){1'b0}};
            tx_pend_reg <= `IRFP_RST_COUNT;
            tx_left_reg <= 8'h00;
            tx_frames_reg <= 8'h00;
            tx_bytes_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            tx_bit_reg <= 3'h0;
            tx_st_reg <= T_IDLE;
            tx_sym_o <= `IRFP_SYM_LEADER;
        end else begin
            if (tx_push) begin
                tx_wr_reg <= tx_wr_reg + 1'b1;
                tx_left_reg <= tx_is_cnt ? wdat : tx_left_reg - 1'b1;
            end
            if (tx_rpop) begin
                tx_rd_reg <= tx_rd_reg + 1'b1;
            end
            tx_used_reg <= tx_used_reg + {{TX_AW{1'b0}}, tx_push} - {{TX_AW{1'b0}}, tx_rpop};
            tx_pend_reg <= tx_pend_reg + {7'h00, tx_data_in} - {7'h00, tx_bdone};  // [RQ3]
            tx_frames_reg <= tx_frames_reg + {7'h00, tx_frame_in} - {7'h00, tx_fpop};
            case (tx_st_reg)
                T_IDLE: begin
                    if (tx_start) begin
                        tx_st_reg <= T_LEAD;
                        tx_sym_o <= `IRFP_SYM_LEADER;  // [RQ17]
                    end
                end
                T_LEAD: begin
                    if (tx_go) begin
                        tx_bytes_reg <= tx_head;
                        if (tx_head == 8'h00) begin
                            tx_st_reg <= T_END;
                            tx_sym_o <= tx_tail;
                        end else begin
                            tx_st_reg <= T_LOAD;
                        end
                    end
                end
                T_LOAD: begin
                    tx_sh_reg <= {1'b0, tx_head[7:1]};
                    tx_bit_reg <= 3'h0;
                    tx_sym_o <= tx_head[0] ? `IRFP_SYM_BIT1 : `IRFP_SYM_BIT0;
                    tx_st_reg <= T_BITS;
                end
                T_BITS: begin
                    if (tx_go) begin
                        if (tx_bit_reg == 3'h7) begin
                            tx_bytes_reg <= tx_bytes_reg - 1'b1;
                            if (tx_bytes_reg == 8'h01) begin
                                tx_st_reg <= T_END;
                                tx_sym_o <= tx_tail;  // [RQ17] [RQ20]
                            end else begin
                                tx_st_reg <= T_LOAD;
                            end
                        end else begin
                            tx_bit_reg <= tx_bit_reg + 1'b1;
                            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                            tx_sym_o <= tx_sh_reg[0] ? `IRFP_SYM_BIT1 : `IRFP_SYM_BIT0;
                        end
                    end
                end
                T_END: begin
                    if (tx_go) begin
                        tx_st_reg <= T_SPACE;
                        tx_sym_o <= `IRFP_SYM_SPACE;  // [RQ17]
                    end
                end
                T_SPACE: begin
                    if (tx_go) begin
                        tx_st_reg <= T_IDLE;
                    end
                end
                default: begin
                    tx_st_reg <= T_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // read mux and acknowledge
    reg [7:0] rdat;
    always @* begin
        rdat = 8'h00;
        case (idx)
            `IRFP_IDX_EVENT: rdat = {3'h0, event_reg, 4'h0};
            `IRFP_IDX_CTRL: rdat = {4'h0, ctrl_reg};
            `IRFP_IDX_STAT: rdat = {4'h0, tx_done_reg, rx_done_reg, 1'b0, rx_ovf_reg};
            `IRFP_IDX_RXCNT: rdat = rx_fill_reg;  // [RQ2]
            `IRFP_IDX_TXCNT: rdat = tx_pend_reg;  // [RQ3]
            `IRFP_IDX_RXPORT: rdat = (rx_fill_reg != 0) ? rx_mem[rx_rd_reg] : `IRFP_EMPTY_READ; // [RQ4] [RQ16]
            `IRFP_IDX_TXERR: rdat = {7'h00, tx_err_reg};
            default: rdat = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req_take;
            if (rd_acc) begin
                wb_dat_o <= {24'h000000, rdat};
            end else if (req_take) begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule // irfp_top

//--- shared/irfp_regs.vh
// register indices, field positions, reset values and symbol codes of the infrared fifo port
`ifndef IRFP_REGS_VH
`define IRFP_REGS_VH
// ==========================================================
// register indices (byte address is four times the index)
`define IRFP_IDX_EVENT 8'h90
`define IRFP_IDX_CTRL 8'hB0
`define IRFP_IDX_STAT 8'hB1
`define IRFP_IDX_RXCNT 8'hB2
`define IRFP_IDX_TXCNT 8'hB3
`define IRFP_IDX_RXPORT 8'hB4
`define IRFP_IDX_TXPORT 8'hB5
`define IRFP_IDX_TXERR 8'hB6
// ==========================================================
// field positions
`define IRFP_CTRL_START 0
`define IRFP_CTRL_FORMAT 1
`define IRFP_CTRL_RXIE 2
`define IRFP_CTRL_TXIE 3
`define IRFP_STAT_RXOVF 0
`define IRFP_STAT_RXDONE 2
`define IRFP_STAT_TXDONE 3
`define IRFP_EVENT_IR 4
`define IRFP_TXERR_LEN 0
// ==========================================================
// reset values and limits
`define IRFP_RST_CTRL 4'h0
`define IRFP_RST_COUNT 8'h00
`define IRFP_EMPTY_READ 8'hFF
`define IRFP_MAX_COUNT 8'hFF
// ==========================================================
// symbols handed to the pulse encoder
`define IRFP_SYM_LEADER 3'h0
`define IRFP_SYM_BIT0 3'h1
`define IRFP_SYM_BIT1 3'h2
`define IRFP_SYM_STOP 3'h3
`define IRFP_SYM_TRAILER 3'h4
`define IRFP_SYM_SPACE 3'h5
`endif

//--- verification/irfp_top_asserts.sv
// checker of the infrared fifo port bus and symbol timing
`timescale 1ns/1ps
`include "irfp_regs.vh"
module irfp_top_asserts (
    // clock, reset and bus
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [11:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    // symbol stream and mode
    input wire tx_sym_valid_o, tx_sym_ready_i, ir_enable_o, ir_format_o, irq_o,
    input wire [2:0] tx_sym_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctl_wr = req & wb_we_i & (wb_adr_i == 12'h2C0);
    wire sym_take = tx_sym_valid_o & tx_sym_ready_i;
    property p_ack_lat; req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_cause; $rose(wb_ack_o) |-> $past(req); endproperty
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    property p_en_cause; $changed(ir_enable_o) |-> $past(ctl_wr); endproperty
    property p_fmt_cause; $changed(ir_format_o) |-> $past(ctl_wr); endproperty
    property p_sym_hold;
        tx_sym_valid_o && !tx_sym_ready_i |=> tx_sym_valid_o && $stable(tx_sym_o);
    endproperty
    property p_space_idle; sym_take && tx_sym_o == `IRFP_SYM_SPACE |=> !tx_sym_valid_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
    a_en_cause: assert property (p_en_cause) else $error("enable moved");
    a_fmt_cause: assert property (p_fmt_cause) else $error("format moved");
    a_sym_hold: assert property (p_sym_hold) else $error("symbol dropped");
    a_space_idle: assert property (p_space_idle) else $error("no idle");
    c_read: cover property (req && !wb_we_i);
    c_leader: cover property (sym_take && tx_sym_o == `IRFP_SYM_LEADER);
    c_irq: cover property ($rose(irq_o));
endmodule // irfp_top_asserts
bind irfp_top irfp_top_asserts irfp_top_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .tx_sym_valid_o(tx_sym_valid_o),
    .tx_sym_ready_i(tx_sym_ready_i), .ir_enable_o(ir_enable_o), .ir_format_o(ir_format_o),
    .irq_o(irq_o), .tx_sym_o(tx_sym_o));

//--- verification/irfp_far_end.sv
// far-end model: pulse decoder bytes in, pulse encoder symbols out
`timescale 1ns/1ps
module irfp_far_end (
    input wire clk_i,
    input wire tx_sym_valid_i,
    input wire [2:0] tx_sym_i,
    output logic tx_sym_ready_o = 1'b0,
    output logic rx_byte_valid_o = 1'b0,
    output logic [7:0] rx_byte_o = 8'h00,
    output logic rx_frame_end_o = 1'b0
);
    logic slow = 1'b1;
    logic [2:0] sym_q[$];
    // encoder: ready every other cycle when slow
    always @(posedge clk_i) begin
        tx_sym_ready_o <= slow ? ~tx_sym_ready_o : 1'b1;
        if (tx_sym_valid_i && tx_sym_ready_o) sym_q.push_back(tx_sym_i);
    end
    task send_byte(input logic [7:0] b);
        @(posedge clk_i);
        rx_byte_valid_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge clk_i);
        rx_byte_valid_o <= 1'b0;
        rx_byte_o <= ~b;
    endtask
    task end_frame;
        @(posedge clk_i);
        rx_frame_end_o <= 1'b1;
        @(posedge clk_i);
        rx_frame_end_o <= 1'b0;
    endtask
endmodule // irfp_far_end

//--- verification/test_irfp_top.sv
// self-checking bench of the infrared fifo port
`timescale 1ns/1ps
`include "irfp_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_irfp_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    wire [31:0] dat_o;
    wire ack, rxv, rxe, tv, tr, en, fmt, irq;
    wire [7:0] rxb;
    wire [2:0] ts;
    int err_total = 0;
    int checks_done = 0;
    irfp_top irfp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .rx_frame_end_i(rxe),
        .tx_sym_valid_o(tv), .tx_sym_o(ts), .tx_sym_ready_i(tr), .ir_enable_o(en),
        .ir_format_o(fmt), .irq_o(irq));
    irfp_far_end irfp_far_end_i (.clk_i(clk_i), .tx_sym_valid_i(tv), .tx_sym_i(ts),
        .tx_sym_ready_o(tr), .rx_byte_valid_o(rxv), .rx_byte_o(rxb), .rx_frame_end_o(rxe));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one classic wishbone cycle, read data left in rdat
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task rchk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK(rdat, {24'h000000, e})
    endtask
    task t_reset;
        rchk(`IRFP_IDX_EVENT, 8'h00);
        rchk(`IRFP_IDX_STAT, 8'h00);
        rchk(`IRFP_IDX_RXCNT, `IRFP_RST_COUNT);
        rchk(`IRFP_IDX_TXCNT, `IRFP_RST_COUNT);
        rchk(`IRFP_IDX_RXPORT, `IRFP_EMPTY_READ);
        rchk(`IRFP_IDX_CTRL, 8'h00);
        rchk(8'h91, 8'h00);
        $display("reset values done");
    endtask
    task t_ctrl;
        bus(1'b1, `IRFP_IDX_CTRL, 8'h02); // format before enable
        `CHK({en, fmt}, 2'b01)
        bus(1'b1, `IRFP_IDX_CTRL, 8'h0F);
        `CHK({en, fmt}, 2'b11)
        rchk(`IRFP_IDX_CTRL, 8'h0F);
        $display("control done");
    endtask
    task t_rx;
        logic [7:0] e [5];
        e = '{8'h02, 8'h11, 8'h22, 8'h01, 8'h33};
        irfp_far_end_i.send_byte(8'h11);
        irfp_far_end_i.send_byte(8'h22);
        irfp_far_end_i.end_frame;
        irfp_far_end_i.send_byte(8'h33);
        irfp_far_end_i.end_frame;
        repeat (2) @(posedge clk_i);
        rchk(`IRFP_IDX_RXCNT, 8'h05);
        rchk(`IRFP_IDX_EVENT, 8'h10);
        `CHK(irq, 1'b1)
        bus(1'b1, `IRFP_IDX_STAT, 8'hFF);
        rchk(`IRFP_IDX_STAT, 8'h04);
        for (int i = 0; i < 5; i++) begin
            rchk(`IRFP_IDX_RXPORT, e[i]);
            rchk(`IRFP_IDX_RXCNT, 8'(4 - i));
        end
        rchk(`IRFP_IDX_RXPORT, 8'hFF);
        bus(1'b1, `IRFP_IDX_STAT, 8'h00);
        rchk(`IRFP_IDX_STAT, 8'h00);
        `CHK(irq, 1'b0)
        bus(1'b1, `IRFP_IDX_EVENT, 8'h00);
        rchk(`IRFP_IDX_EVENT, 8'h00);
        $display("receive frames done");
    endtask
    task t_tx;
        int n;
        irfp_far_end_i.sym_q.delete();
        bus(1'b1, `IRFP_IDX_TXPORT, 8'h01); // count byte first
        rchk(`IRFP_IDX_TXCNT, 8'h00);
        bus(1'b1, `IRFP_IDX_TXPORT, 8'hA5);
        rchk(`IRFP_IDX_TXCNT, 8'h01);
        n = 0;
        do begin
            bus(1'b0, `IRFP_IDX_STAT, 8'h00);
            n++;
        end while (rdat[3] !== 1'b1 && n < 200);
        `CHK(rdat[7:0], 8'h08)
        `CHK(irq, 1'b1)
        rchk(`IRFP_IDX_TXCNT, 8'h00);
        rchk(`IRFP_IDX_EVENT, 8'h10);
        `CHK(irfp_far_end_i.sym_q.size(), 11)
        `CHK(irfp_far_end_i.sym_q[0], `IRFP_SYM_LEADER)
        for (int i = 0; i < 8; i++) begin
            `CHK(irfp_far_end_i.sym_q[i + 1], ((8'hA5 >> i) & 1) ? 3'h2 : 3'h1)
        end
        `CHK(irfp_far_end_i.sym_q[9], `IRFP_SYM_TRAILER)
        `CHK(irfp_far_end_i.sym_q[10], `IRFP_SYM_SPACE)
        bus(1'b1, `IRFP_IDX_STAT, 8'h00);
        rchk(`IRFP_IDX_STAT, 8'h00);
        `CHK(irq, 1'b0)
        // empty frame in the first air format: leader, stop, space
        bus(1'b1, `IRFP_IDX_CTRL, 8'h0C); // format before enable
        bus(1'b1, `IRFP_IDX_CTRL, 8'h0D);
        `CHK(fmt, 1'b0)
        irfp_far_end_i.sym_q.delete();
        bus(1'b1, `IRFP_IDX_TXPORT, 8'h00); // count byte only
        n = 0;
        do begin
            bus(1'b0, `IRFP_IDX_STAT, 8'h00);
            n++;
        end while (rdat[3] !== 1'b1 && n < 200);
        `CHK(rdat[7:0], 8'h08)
        `CHK(irfp_far_end_i.sym_q.size(), 3)
        `CHK(irfp_far_end_i.sym_q[0], `IRFP_SYM_LEADER)
        `CHK(irfp_far_end_i.sym_q[1], `IRFP_SYM_STOP)
        `CHK(irfp_far_end_i.sym_q[2], `IRFP_SYM_SPACE)
        bus(1'b1, `IRFP_IDX_STAT, 8'h00);
        rchk(`IRFP_IDX_STAT, 8'h00);
        $display("transmit frame done");
    endtask
    task t_rx_full;
        for (int i = 0; i < 254; i++) irfp_far_end_i.send_byte(8'(i));
        irfp_far_end_i.end_frame;
        repeat (2) @(posedge clk_i);
        rchk(`IRFP_IDX_RXCNT, `IRFP_MAX_COUNT);
        irfp_far_end_i.send_byte(8'h77);
        irfp_far_end_i.end_frame;
        repeat (2) @(posedge clk_i);
        rchk(`IRFP_IDX_RXCNT, 8'hFF);
        rchk(`IRFP_IDX_STAT, 8'h05);
        rchk(`IRFP_IDX_RXPORT, 8'hFE);
        $display("receive overflow done");
    endtask
    task t_tx_full;
        bus(1'b1, `IRFP_IDX_CTRL, 8'h0E); // enable off, no traffic expected
        bus(1'b1, `IRFP_IDX_TXPORT, 8'hFF);
        for (int i = 0; i < 255; i++) bus(1'b1, `IRFP_IDX_TXPORT, 8'(i));
        rchk(`IRFP_IDX_TXCNT, `IRFP_MAX_COUNT);
        rchk(`IRFP_IDX_TXERR, 8'h00);
        `CHK(tv, 1'b0)
        bus(1'b1, `IRFP_IDX_TXPORT, 8'h5A);
        rchk(`IRFP_IDX_TXERR, 8'h01);
        rchk(`IRFP_IDX_TXCNT, 8'hFF);
        $display("transmit limit done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_ctrl;
        t_rx;
        t_tx;
        t_rx_full;
        t_tx_full;
        results;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        results;
    end
endmodule // test_irfp_top
